// file: rtl/spsp_map.svh
// Constants for the standalone port status pin block.
// Assumes inclusion by bare name from the design file.
`ifndef SPSP_MAP_SVH
`define SPSP_MAP_SVH

// Orientation encodings
`define SPSP_ORIENT_CC1      1'h0
`define SPSP_ORIENT_CC2      1'h1
// Plug-present encodings
`define SPSP_PLUG_NONE       1'h0
`define SPSP_PLUG_BOTH       1'h1
// Reset values
`define SPSP_OC_N_RST        1'h1
`define SPSP_BIT_RST         1'h0
// Both synchroniser stages clear to all zero
`define SPSP_SYNC_RST        5'h00

`endif

// file: rtl/spsp_pkg.sv
// Types shared by the standalone port status pin block.
// Assumes no surroundings beyond the compiler.
package spsp_pkg;
   // Standalone operating role
   typedef enum logic [1:0] {
      SPSP_ROLE_OFF = 2'h0,
      SPSP_ROLE_DFP = 2'h1,
      SPSP_ROLE_UFP = 2'h3
   } spsp_role_type;
endpackage

// file: rtl/spsp_status_pins.sv
// Standalone port status pins: plug-present, orientation, overcurrent, power enable.
// Assumes detection inputs are asynchronous levels from analog comparators and
// pins; the role comes from configuration logic on core_clk.
// Detection inputs are steady levels; a glitch shorter than one clock may go unseen.
`include "spsp_map.svh"
`timescale 1ns/10ps
`default_nettype none

module spsp_status_pins (
   // Clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  sys_rst,
   // Configuration (same clock domain)
   input  wire spsp_pkg::spsp_role_type role,
   // Detection levels (asynchronous)
   input  wire logic                  cableAttached,
   input  wire logic                  rdOnCc2,
   input  wire logic                  cc2Higher,
   input  wire logic                  overcurrentSense,
   // Hub pin (asynchronous)
   input  wire logic                  vbus_switch_enable_in,
   // Status pins
   output logic                       plugPresent,
   output logic                       orientation,
   output logic                       overcurrent_flag_n,
   output logic                       power_switch_irq,
   output logic                       portSwitchEnable
);

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic [4:0] syncA_reg;
   logic [4:0] syncB_reg;

   // Two flops on every asynchronous level before any logic reads it
   // Reset clears both stages so a stale level never leaks past a reset
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         syncA_reg <= `SPSP_SYNC_RST;
         syncB_reg <= `SPSP_SYNC_RST;
      end else begin
         syncA_reg <= {vbus_switch_enable_in, overcurrentSense, cc2Higher, rdOnCc2,
                       cableAttached};
         syncB_reg <= syncA_reg;
      end
   end

   logic attachS, rdCc2S, cc2HiS, ocS, pwrEnS;
   assign {pwrEnS, ocS, cc2HiS, rdCc2S, attachS} = syncB_reg;

   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   function automatic logic isStandalone(input spsp_pkg::spsp_role_type r);
      isStandalone = (r == spsp_pkg::SPSP_ROLE_DFP) || (r == spsp_pkg::SPSP_ROLE_UFP);
   endfunction

   function automatic logic isDfp(input spsp_pkg::spsp_role_type r);
      isDfp = (r == spsp_pkg::SPSP_ROLE_DFP);
   endfunction

   function automatic logic isUfp(input spsp_pkg::spsp_role_type r);
      isUfp = (r == spsp_pkg::SPSP_ROLE_UFP);
   endfunction

   // ------------------------------------------------------------
   // Attach and orientation
   // ------------------------------------------------------------
   logic plugNext;
   logic orientNext;

   assign plugNext = (isStandalone(role) && attachS) ? `SPSP_PLUG_BOTH : `SPSP_PLUG_NONE;

   always_comb begin
      if (plugNext != `SPSP_PLUG_BOTH) begin
         orientNext = `SPSP_ORIENT_CC1;
      end else if (isDfp(role)) begin
         orientNext = rdCc2S ? `SPSP_ORIENT_CC2 : `SPSP_ORIENT_CC1;
      end else begin
         orientNext = cc2HiS ? `SPSP_ORIENT_CC2 : `SPSP_ORIENT_CC1;
      end
   end

   // autonomous orientation drive
   // Both pins change on the same edge, so orientation is never seen stale
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         plugPresent <= `SPSP_BIT_RST;
         orientation <= `SPSP_BIT_RST;
      end else begin
         plugPresent <= plugNext;
         orientation <= orientNext;
      end
   end

   // ------------------------------------------------------------
   // Overcurrent and power enable
   // ------------------------------------------------------------
   logic ocEvent;

   assign ocEvent = isDfp(role) && ocS;

   // active-low overcurrent
   // Flag and interrupt update on the same edge from ocEvent
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         overcurrent_flag_n <= `SPSP_OC_N_RST;
         power_switch_irq   <= `SPSP_BIT_RST;
      end else begin
         overcurrent_flag_n <= ~ocEvent;
         power_switch_irq   <= ocEvent;
      end
   end

   // hub power enable
   // Outside DFP mode the hub pin has no meaning, so the switch stays off
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         portSwitchEnable <= `SPSP_BIT_RST;
      end else begin
         portSwitchEnable <= isDfp(role) && pwrEnS;
      end
   end

   // ------------------------------------------------------------
   // Checks: attach and orientation
   // ------------------------------------------------------------
   // Pin to pin: in a standalone role the raw attach level shows three edges later
   chk_plug_follows: assert property (@(posedge core_clk) disable iff (sys_rst)
      (!$past(sys_rst, 3) && !$past(sys_rst, 2) && !$past(sys_rst) &&
       isStandalone($past(role))) |-> (plugPresent == $past(cableAttached, 3)))
      else $error("plug-present does not follow the attach level");

   // A synchronised attach in a standalone role raises plug-present on the next edge
   chk_plug_attach: assert property (@(posedge core_clk) disable iff (sys_rst)
      (isStandalone(role) && attachS) |=> plugPresent)
      else $error("plug-present low with a cable attached");

   // The OFF role never reports a cable, whatever the detector says
   chk_plug_role_off: assert property (@(posedge core_clk) disable iff (sys_rst)
      !isStandalone(role) |=> !plugPresent)
      else $error("plug-present high outside the standalone roles");

   chk_plug_empty: assert property (@(posedge core_clk) disable iff (sys_rst)
      (isStandalone(role) && !attachS) |=> !plugPresent)
      else $error("plug-present high with nothing attached");

   chk_dfp_orient: assert property (@(posedge core_clk) disable iff (sys_rst)
      (isDfp(role) && attachS) |=> (orientation == $past(rdCc2S)))
      else $error("DFP orientation wrong");

   // Pin to pin: DFP orientation is the raw Rd side three edges later
   chk_dfp_pin_orient: assert property (@(posedge core_clk) disable iff (sys_rst)
      (!$past(sys_rst, 3) && !$past(sys_rst, 2) && !$past(sys_rst) && isDfp($past(role)) &&
       $past(cableAttached, 3)) |-> (orientation == $past(rdOnCc2, 3)))
      else $error("DFP orientation does not follow the Rd side");

   chk_ufp_orient: assert property (@(posedge core_clk) disable iff (sys_rst)
      (isUfp(role) && attachS) |=> (orientation == $past(cc2HiS)))
      else $error("UFP orientation wrong");

   // Pin to pin: UFP orientation is the raw higher-CC level three edges later
   chk_ufp_pin_orient: assert property (@(posedge core_clk) disable iff (sys_rst)
      (!$past(sys_rst, 3) && !$past(sys_rst, 2) && !$past(sys_rst) && isUfp($past(role)) &&
       $past(cableAttached, 3)) |-> (orientation == $past(cc2Higher, 3)))
      else $error("UFP orientation does not follow the higher CC");

   chk_orient_auto: assert property (@(posedge core_clk) disable iff (sys_rst)
      ($stable(role) && isDfp(role) && $rose(rdCc2S) && attachS) |=> orientation)
      else $error("orientation did not follow Rd move");

   // ------------------------------------------------------------
   // Checks: overcurrent, power and idle orientation
   // ------------------------------------------------------------
   chk_oc_low: assert property (@(posedge core_clk) disable iff (sys_rst)
      (isDfp(role) && ocS) |=> !overcurrent_flag_n)
      else $error("overcurrent flag not low");

   // Flag stays released unless a DFP overcurrent is sensed, so UFP and OFF never pull it
   chk_oc_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
      !(isDfp(role) && ocS) |=> overcurrent_flag_n)
      else $error("overcurrent flag low without overcurrent");

   // Flag and interrupt must never be caught apart, not even for one edge
   chk_oc_irq_tie: assert property (@(posedge core_clk) disable iff (sys_rst)
      ##1 (overcurrent_flag_n == !power_switch_irq))
      else $error("flag and interrupt disagree");

   // The interrupt rises on the same sensed condition that pulls the flag low
   chk_oc_irq_set: assert property (@(posedge core_clk) disable iff (sys_rst)
      (isDfp(role) && ocS) |=> power_switch_irq)
      else $error("interrupt low during overcurrent");

   // In DFP the switch follows the synchronised hub request one edge later
   chk_pwr_enable: assert property (@(posedge core_clk) disable iff (sys_rst)
      isDfp(role) |=> (portSwitchEnable == $past(pwrEnS)))
      else $error("switch enable does not follow hub");

   // Outside the DFP role the hub pin has no effect on the switch
   chk_pwr_off: assert property (@(posedge core_clk) disable iff (sys_rst)
      !isDfp(role) |=> !portSwitchEnable)
      else $error("switch enabled outside the DFP role");

   // Orientation means nothing without a cable, so it must rest at CC1
   chk_orient_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
      !plugPresent |-> !orientation)
      else $error("orientation set while detached");

endmodule

`default_nettype wire

// file: verif/spsp_hub_model.sv
// Hub-side model that drives the port power request pin.
// Assumes the bench asks for power through wantPower on core_clk.
`timescale 1ns/10ps
`default_nettype none

module spsp_hub_model (
   // Clock and request from the bench
   input  wire logic core_clk,
   input  wire logic wantPower,
   // Pin towards the device
   output var logic  vbus_switch_enable_in
);
   // hub drives request
   // Registered, so the pin only moves just after an edge, as hub logic would;
   // it is unknown until the first edge, which falls inside the bench's reset
   always_ff @(posedge core_clk) begin
      vbus_switch_enable_in <= wantPower;
   end
endmodule

`default_nettype wire

// file: verif/spsp_status_pins_test.sv
// Self-checking bench for the standalone port status pins.
// Assumes the hub model beside it and a 50 MHz core clock.
`timescale 1ns/10ps
`default_nettype none

module spsp_status_pins_test;
   logic                    core_clk, sys_rst, cableAttached, rdOnCc2;
   logic                    cc2Higher, overcurrentSense, wantPower;
   spsp_pkg::spsp_role_type role;
   logic                    plugPresent, orientation, ocN, irq, swEn;
   wire logic               hubEn;
   wire logic [4:0]         outs;
   int                      nErrors, cmpCount;

   assign outs = {plugPresent, orientation, ocN, irq, swEn};

   spsp_hub_model hub (.core_clk(core_clk), .wantPower(wantPower),
                       .vbus_switch_enable_in(hubEn));
   spsp_status_pins dut (.core_clk(core_clk), .sys_rst(sys_rst), .role(role),
      .cableAttached(cableAttached), .rdOnCc2(rdOnCc2), .cc2Higher(cc2Higher),
      .overcurrentSense(overcurrentSense), .vbus_switch_enable_in(hubEn),
      .plugPresent(plugPresent), .orientation(orientation),
      .overcurrent_flag_n(ocN), .power_switch_irq(irq), .portSwitchEnable(swEn));

   // 50 MHz clock
   initial begin
      core_clk = 1'h0;
      forever #10 core_clk = ~core_clk;
   end

   // Compare and count
   task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         nErrors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Inputs {attach, rdCc2, cc2High, oc, power}; outputs {plug, orient, ocN, irq, swEn}
   // Waits past the hub flop, the two sync flops and the output flop before judging
   task automatic step(input spsp_pkg::spsp_role_type r, input logic [4:0] in,
                       input logic [4:0] exp);
      @(posedge core_clk);
      role <= r;
      {cableAttached, rdOnCc2, cc2Higher, overcurrentSense, wantPower} <= in;
      repeat (6) @(posedge core_clk);
      #1 chk(outs, exp);
   endtask

   task automatic t_dfp;
      step(spsp_pkg::SPSP_ROLE_DFP, 5'h10, 5'h14);
      step(spsp_pkg::SPSP_ROLE_DFP, 5'h18, 5'h1C);
      step(spsp_pkg::SPSP_ROLE_DFP, 5'h08, 5'h04);
   endtask

   task automatic t_ufp;
      step(spsp_pkg::SPSP_ROLE_UFP, 5'h14, 5'h1C);
      step(spsp_pkg::SPSP_ROLE_UFP, 5'h10, 5'h14);
      step(spsp_pkg::SPSP_ROLE_UFP, 5'h1B, 5'h14);
   endtask

   task automatic t_oc;
      step(spsp_pkg::SPSP_ROLE_DFP, 5'h02, 5'h02);
      step(spsp_pkg::SPSP_ROLE_DFP, 5'h00, 5'h04);
   endtask

   task automatic t_pwr;
      step(spsp_pkg::SPSP_ROLE_DFP, 5'h01, 5'h05);
      step(spsp_pkg::SPSP_ROLE_DFP, 5'h03, 5'h03);
      step(spsp_pkg::SPSP_ROLE_OFF, 5'h1B, 5'h04);
   endtask

   // Reset in mid-run drops every pin to idle and flushes the synchronisers
   task automatic t_rst;
      step(spsp_pkg::SPSP_ROLE_DFP, 5'h1B, 5'h1B);
      @(posedge core_clk);
      sys_rst <= 1'h1;
      repeat (2) @(posedge core_clk);
      #1 chk(outs, 5'h04);
      @(posedge core_clk);
      sys_rst <= 1'h0;
      @(posedge core_clk);
      #1 chk(outs, 5'h04);
      repeat (3) @(posedge core_clk);
      #1 chk(outs, 5'h1B);
   endtask

   task automatic closeOut;
      if (nErrors == 0 && cmpCount > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Main sequence: reset for 8 cycles, then each scenario in turn
   initial begin
      sys_rst = 1'h1;
      role = spsp_pkg::SPSP_ROLE_OFF;
      {cableAttached, rdOnCc2, cc2Higher, overcurrentSense, wantPower} = 5'h00;
      nErrors = 0;
      cmpCount = 0;
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'h0;
      #1 chk(outs, 5'h04);
      t_dfp();
      t_ufp();
      t_oc();
      t_pwr();
      t_rst();
      closeOut();
   end
endmodule

`default_nettype wire
